/* drkp_panel.sv */
// Keypad and display controller of the drive front panel, with AHB-Lite registers
//
// Design decisions made here: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
`include "drkp_params.svh"

module drkp_panel
    import drkp_pkg::*;
#(
    parameter logic [`DRKP_DB_W-1:0] DB_CYCLES = `DRKP_DB_W'(`DRKP_DEBOUNCE_CYC)
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Panel keys, high when pressed
    input wire logic param_mode_key,
    input wire logic data_key,
    input wire logic enter_key,
    input wire logic shift_key,
    input wire logic up_key,
    input wire logic down_key,
    input wire logic forward_run_key,
    input wire logic reverse_run_key,
    input wire logic stop_key,
    input wire logic reset_key,
    // Terminals
    input wire logic fault_clear_input,
    input wire logic [7:0] multifunction_inputs,
    // Drive core
    input wire logic drive_running,
    input wire logic fault_event,
    input wire logic [15:0] panel_pot_input,
    input wire logic [15:0] ext_speed_input,
    input wire logic [15:0] out_freq,
    input wire logic [15:0] out_current,
    input wire logic [15:0] out_voltage,
    input wire logic [15:0] unitless_value,
    output logic run_fwd,
    output logic run_rev,
    output logic fault_latched,
    output logic [15:0] speed_cmd,
    // Indicators and display
    output logic fwd_lamp,
    output logic rev_lamp,
    output logic [3:0] display_kind,
    output logic [15:0] display_value,
    output logic [1:0] cursor_pos,
    output logic cursor_flash,
    // Non-volatile store
    output logic nvm_write,
    output logic [4:0] nvm_addr,
    output logic [15:0] nvm_data
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [`DRKP_NKEY-1:0] raw_keys;
    logic [`DRKP_NKEY-1:0] key_level;
    logic [`DRKP_NKEY-1:0] key_press;
    logic [7:0] din_s1_q;
    logic [7:0] din_s2_q;
    logic [15:0] pmem [`DRKP_NPARAM];
    drkp_mode_t mode_q;
    logic [4:0] pcode_q;
    logic [15:0] edit_q;
    logic [15:0] orig_q;
    logic [1:0] cur_q;
    logic [2:0] dsel_q;
    logic [15:0] freq_q;
    logic run_fwd_q;
    logic run_rev_q;
    logic fault_q;
    logic [15:0] speed_q;
    logic [3:0] dkind_q;
    logic [15:0] dval_q;
    logic nvm_wr_q;
    logic [4:0] nvm_addr_q;
    logic [15:0] nvm_data_q;
    logic pend_q;
    logic pwrite_q;
    logic [7:0] paddr_q;
    logic [4:0] pidx_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic flash_q;
    logic bus_wr;
    logic store_now;
    logic [15:0] fsrc;
    logic [15:0] mon_sel;
    drkp_dir_t dir_lim;

    // Step for the digit under the cursor; cursor 0 is the leftmost digit
    function automatic logic [15:0] digit_step(input logic [1:0] cur);
        case (cur)
            2'h0: digit_step = 16'h1000;
            2'h1: digit_step = 16'h0100;
            2'h2: digit_step = 16'h0010;
            default: digit_step = 16'h0001;
        endcase
    endfunction : digit_step

    function automatic logic is_wr(input logic [7:0] ofs, input logic [7:0] target,
                                   input logic pend, input logic pwr);
        is_wr = pend && pwr && (ofs == target);
    endfunction : is_wr

    // ----------------------------------------
    // Key conditioning
    // ----------------------------------------
    assign raw_keys = {fault_clear_input, reset_key, stop_key, reverse_run_key,
                       forward_run_key, down_key, up_key, shift_key, enter_key,
                       data_key, param_mode_key};

    genvar gk;
    generate
        for (gk = 0; gk < `DRKP_NKEY; gk++) begin : g_key
            drkp_debounce #(
                .DB_CYCLES(DB_CYCLES)
            ) u_db (
                .hclk(hclk),
                .hresetn(hresetn),
                .raw_in(raw_keys[gk]),
                .level_q(key_level[gk]),
                .press_q(key_press[gk])
            );
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            din_s1_q <= 8'h00;
            din_s2_q <= 8'h00;
        end else begin
            din_s1_q <= multifunction_inputs;
            din_s2_q <= din_s1_q;
        end
    end

    // ----------------------------------------
    // Parameter store
    // ----------------------------------------
    assign fsrc = pmem[`DRKP_PIDX_FSRC];
    assign mon_sel = pmem[`DRKP_PIDX_MON];
    assign dir_lim = drkp_dir_t'(pmem[`DRKP_PIDX_DIR][1:0]);
    assign bus_wr = is_wr(paddr_q, `DRKP_OFS_PDATA, pend_q, pwrite_q);
    assign store_now = (mode_q == DRKP_MODE_PEDIT) &&
                       (key_press[`DRKP_K_ENTER] || key_press[`DRKP_K_DATA]);

    // Bus write is applied after a panel store, so software has the last word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < `DRKP_NPARAM; i++) begin
                pmem[i] <= 16'h0000;
            end
            pmem[`DRKP_PIDX_MON] <= `DRKP_RST_MON;
            pmem[`DRKP_PIDX_FSRC] <= `DRKP_RST_FSRC;
        end else begin
            if (store_now) begin
                pmem[pcode_q] <= edit_q;
            end
            if (bus_wr) begin
                pmem[pidx_q] <= hwdata[15:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nvm_wr_q <= 1'b0;
            nvm_addr_q <= 5'h00;
            nvm_data_q <= 16'h0000;
        end else begin
            nvm_wr_q <= store_now;
            if (store_now) begin
                nvm_addr_q <= pcode_q;
                nvm_data_q <= edit_q;
            end
        end
    end

    // ----------------------------------------
    // Panel mode, parameter code and entry
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= DRKP_MODE_OPER;
            pcode_q <= 5'h00;
            edit_q <= 16'h0000;
            orig_q <= 16'h0000;
            cur_q <= 2'h0;
            flash_q <= 1'b0;
        end else begin
            // Flash trails edit mode by one cycle so the pin comes from a flop
            flash_q <= (mode_q == DRKP_MODE_PEDIT);
            case (mode_q)
                DRKP_MODE_OPER: begin
                    if (key_press[`DRKP_K_PARAM]) begin
                        mode_q <= DRKP_MODE_PCODE;
                    end else if (key_press[`DRKP_K_DOWN]) begin
                        mode_q <= DRKP_MODE_PCODE;
                        pcode_q <= `DRKP_PIDX_MON;
                    end
                end
                DRKP_MODE_PCODE: begin
                    if (key_press[`DRKP_K_PARAM]) begin
                        mode_q <= DRKP_MODE_OPER;
                    end else if (key_press[`DRKP_K_DATA]) begin
                        mode_q <= DRKP_MODE_PEDIT;
                        edit_q <= pmem[pcode_q];
                        orig_q <= pmem[pcode_q];
                        cur_q <= 2'h0;
                    end else if (key_press[`DRKP_K_UP]) begin
                        pcode_q <= pcode_q + 5'h01;
                    end else if (key_press[`DRKP_K_DOWN]) begin
                        pcode_q <= pcode_q - 5'h01;
                    end
                end
                DRKP_MODE_PEDIT: begin
                    if (store_now) begin
                        mode_q <= DRKP_MODE_PCODE;
                    end else if (key_press[`DRKP_K_PARAM]) begin
                        mode_q <= DRKP_MODE_OPER;
                    end else if (key_press[`DRKP_K_SHIFT]) begin
                        cur_q <= cur_q + 2'h1;
                    end else if (key_press[`DRKP_K_UP]) begin
                        edit_q <= edit_q + digit_step(cur_q);
                    end else if (key_press[`DRKP_K_DOWN]) begin
                        edit_q <= edit_q - digit_step(cur_q);
                    end else if (key_press[`DRKP_K_RESET] && !fault_q) begin
                        edit_q <= orig_q;
                    end
                end
                default: begin
                    mode_q <= DRKP_MODE_OPER;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Monitor cycling
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dsel_q <= 3'h0;
        end else if (mode_q == DRKP_MODE_OPER && drive_running &&
                     key_press[`DRKP_K_SHIFT]) begin
            dsel_q <= (dsel_q >= 3'h4) ? 3'h0 : dsel_q + 3'h1;
        end
    end

    // ----------------------------------------
    // Frequency setting
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            freq_q <= 16'h0000;
        end else begin
            if (mode_q == DRKP_MODE_OPER && key_press[`DRKP_K_UP] &&
                fsrc == `DRKP_FSRC_PANEL) begin
                freq_q <= freq_q + `DRKP_FREQ_STEP;
            end
            if (is_wr(paddr_q, `DRKP_OFS_FREQ, pend_q, pwrite_q)) begin
                freq_q <= hwdata[15:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            speed_q <= 16'h0000;
        end else if (fsrc == `DRKP_FSRC_PANEL) begin
            speed_q <= freq_q;
        end else if (fsrc == `DRKP_FSRC_POT) begin
            speed_q <= panel_pot_input;
        end else begin
            speed_q <= ext_speed_input;
        end
    end

    // ----------------------------------------
    // Run commands
    // ----------------------------------------
    // A latched fault drops both run commands until it is released
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_fwd_q <= 1'b0;
            run_rev_q <= 1'b0;
        end else if (fault_q || key_press[`DRKP_K_STOP]) begin
            run_fwd_q <= 1'b0;
            run_rev_q <= 1'b0;
        end else if (key_press[`DRKP_K_FWD]) begin
            if (run_fwd_q && dir_lim != DRKP_DIR_FWD_ONLY) begin
                run_fwd_q <= 1'b0;
            end else if (dir_lim != DRKP_DIR_REV_ONLY) begin
                run_fwd_q <= 1'b1;
                run_rev_q <= 1'b0;
            end
        end else if (key_press[`DRKP_K_REV]) begin
            if (run_rev_q && dir_lim != DRKP_DIR_REV_ONLY) begin
                run_rev_q <= 1'b0;
            end else if (dir_lim != DRKP_DIR_FWD_ONLY) begin
                run_rev_q <= 1'b1;
                run_fwd_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Fault latch
    // ----------------------------------------
    // A new fault in the clearing cycle keeps the latch set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_q <= 1'b0;
        end else if (fault_event) begin
            fault_q <= 1'b1;
        end else if (key_press[`DRKP_K_RESET] || key_level[`DRKP_K_FCLR]) begin
            fault_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Display
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dkind_q <= DRKP_DK_FCMD;
            dval_q <= 16'h0000;
        end else if (mode_q == DRKP_MODE_PCODE) begin
            dkind_q <= DRKP_DK_PCODE;
            dval_q <= {11'h000, pcode_q};
        end else if (mode_q == DRKP_MODE_PEDIT) begin
            dkind_q <= DRKP_DK_PVAL;
            dval_q <= edit_q;
        end else if (drive_running && mon_sel == `DRKP_MON_DIN) begin
            dkind_q <= DRKP_DK_DIN;
            dval_q <= {8'h00, din_s2_q};
        end else begin
            case (dsel_q)
                3'h1: begin
                    dkind_q <= DRKP_DK_FOUT;
                    dval_q <= out_freq;
                end
                3'h2: begin
                    dkind_q <= DRKP_DK_IOUT;
                    dval_q <= out_current;
                end
                3'h3: begin
                    dkind_q <= DRKP_DK_VOUT;
                    dval_q <= out_voltage;
                end
                3'h4: begin
                    dkind_q <= DRKP_DK_UNIT;
                    dval_q <= unitless_value;
                end
                default: begin
                    dkind_q <= DRKP_DK_FCMD;
                    dval_q <= speed_q;
                end
            endcase
        end
    end

    // ----------------------------------------
    // AHB-Lite slave
    // ----------------------------------------
    // One wait state on every transfer keeps read data straight from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_q <= 1'b0;
            pwrite_q <= 1'b0;
            paddr_q <= 8'h00;
            hreadyout_q <= 1'b1;
        end else if (pend_q) begin
            pend_q <= 1'b0;
            hreadyout_q <= 1'b1;
        end else if (hsel && htrans[1] && hready) begin
            pend_q <= 1'b1;
            pwrite_q <= hwrite;
            paddr_q <= haddr;
            hreadyout_q <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pidx_q <= 5'h00;
        end else if (is_wr(paddr_q, `DRKP_OFS_PIDX, pend_q, pwrite_q)) begin
            pidx_q <= hwdata[4:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h00000000;
        end else if (pend_q && !pwrite_q) begin
            case (paddr_q)
                `DRKP_OFS_STATUS: begin
                    hrdata_q <= {21'h000000, dsel_q, 1'b0, cur_q, fault_q, run_rev_q,
                                 run_fwd_q, mode_q};
                end
                `DRKP_OFS_FREQ: hrdata_q <= {16'h0000, freq_q};
                `DRKP_OFS_PIDX: hrdata_q <= {27'h0000000, pidx_q};
                `DRKP_OFS_PDATA: hrdata_q <= {16'h0000, pmem[pidx_q]};
                `DRKP_OFS_DISP: hrdata_q <= {12'h000, dkind_q, dval_q};
                default: hrdata_q <= 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign run_fwd = run_fwd_q;
    assign run_rev = run_rev_q;
    assign fwd_lamp = run_fwd_q;
    assign rev_lamp = run_rev_q;
    assign fault_latched = fault_q;
    assign speed_cmd = speed_q;
    assign display_kind = dkind_q;
    assign display_value = dval_q;
    assign cursor_pos = cur_q;
    assign cursor_flash = flash_q;
    assign nvm_write = nvm_wr_q;
    assign nvm_addr = nvm_addr_q;
    assign nvm_data = nvm_data_q;

endmodule : drkp_panel

/* drkp_params.svh */
// Offsets, field positions, reset values and timing counts of the keypad panel
`ifndef DRKP_PARAMS_SVH
`define DRKP_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DRKP_OFS_STATUS 8'h00
`define DRKP_OFS_FREQ 8'h04
`define DRKP_OFS_PIDX 8'h08
`define DRKP_OFS_PDATA 8'h0C
`define DRKP_OFS_DISP 8'h10

// ----------------------------------------
// Status and display field positions
// ----------------------------------------
`define DRKP_ST_MODE 0
`define DRKP_ST_RUNF 2
`define DRKP_ST_RUNR 3
`define DRKP_ST_FAULT 4
`define DRKP_ST_CUR 5
`define DRKP_ST_DSEL 8
`define DRKP_DISP_KIND 16

// ----------------------------------------
// Parameter store
// ----------------------------------------
`define DRKP_NPARAM 32
`define DRKP_PIDX_MON 5'h04
`define DRKP_PIDX_FSRC 5'h08
`define DRKP_PIDX_DIR 5'h09
`define DRKP_RST_MON 16'h0001
`define DRKP_RST_FSRC 16'h0001
`define DRKP_MON_DIN 16'h000B
`define DRKP_FSRC_PANEL 16'h0000
`define DRKP_FSRC_POT 16'h0001
`define DRKP_FREQ_STEP 16'h0001

// ----------------------------------------
// Key indexes
// ----------------------------------------
`define DRKP_NKEY 11
`define DRKP_K_PARAM 0
`define DRKP_K_DATA 1
`define DRKP_K_ENTER 2
`define DRKP_K_SHIFT 3
`define DRKP_K_UP 4
`define DRKP_K_DOWN 5
`define DRKP_K_FWD 6
`define DRKP_K_REV 7
`define DRKP_K_STOP 8
`define DRKP_K_RESET 9
`define DRKP_K_FCLR 10

// ----------------------------------------
// Timing
// ----------------------------------------
`define DRKP_CLK_KHZ 25000
`define DRKP_DEBOUNCE_MS 10
`define DRKP_DEBOUNCE_CYC (`DRKP_DEBOUNCE_MS * `DRKP_CLK_KHZ)
`define DRKP_DB_W 18

`endif

/* drkp_pkg.sv */
// Types shared by the keypad panel design
package drkp_pkg;

    typedef enum logic [1:0] {
        DRKP_MODE_OPER = 2'b00,
        DRKP_MODE_PCODE = 2'b01,
        DRKP_MODE_PEDIT = 2'b10
    } drkp_mode_t;

    typedef enum logic [3:0] {
        DRKP_DK_FCMD = 4'h0,
        DRKP_DK_FOUT = 4'h1,
        DRKP_DK_IOUT = 4'h2,
        DRKP_DK_VOUT = 4'h3,
        DRKP_DK_UNIT = 4'h4,
        DRKP_DK_DIN = 4'h5,
        DRKP_DK_PCODE = 4'h6,
        DRKP_DK_PVAL = 4'h7
    } drkp_dkind_t;

    typedef enum logic [1:0] {
        DRKP_DIR_BOTH = 2'b00,
        DRKP_DIR_FWD_ONLY = 2'b01,
        DRKP_DIR_REV_ONLY = 2'b10
    } drkp_dir_t;

endpackage : drkp_pkg

/* drkp_debounce.sv */
// Synchroniser and debouncer for one panel key or terminal
`timescale 1ns/100ps
`include "drkp_params.svh"

module drkp_debounce #(
    parameter logic [`DRKP_DB_W-1:0] DB_CYCLES = `DRKP_DB_W'(`DRKP_DEBOUNCE_CYC)
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Raw pin, high when pressed
    input wire logic raw_in,
    // Clean level and press-edge pulse
    output logic level_q,
    output logic press_q
);

    logic sync1_q;
    logic sync2_q;
    logic [`DRKP_DB_W-1:0] cnt_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    // Level must stay different for the whole window before it is taken
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
            level_q <= 1'b0;
            press_q <= 1'b0;
        end else begin
            press_q <= 1'b0;
            if (sync2_q == level_q) begin
                cnt_q <= '0;
            end else if (cnt_q >= DB_CYCLES - `DRKP_DB_W'(1)) begin
                cnt_q <= '0;
                level_q <= sync2_q;
                press_q <= sync2_q;
            end else begin
                cnt_q <= cnt_q + `DRKP_DB_W'(1);
            end
        end
    end

endmodule : drkp_debounce

/* drkp_panel_monitor.sv */
// Checker of key-to-output relations of the keypad panel
`timescale 1ns/100ps
module drkp_panel_monitor (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Causes
    input wire logic forward_run_key,
    input wire logic reverse_run_key,
    input wire logic reset_key,
    input wire logic fault_clear_input,
    input wire logic fault_event,
    input wire logic drive_running,
    input wire logic [7:0] multifunction_inputs,
    // Effects
    input wire logic run_fwd,
    input wire logic run_rev,
    input wire logic fwd_lamp,
    input wire logic rev_lamp,
    input wire logic fault_latched,
    input wire logic nvm_write,
    input wire logic [3:0] display_kind,
    input wire logic [15:0] display_value
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Sync and display register settle well inside six steady samples
    sequence din_steady;
        $stable(multifunction_inputs) [*6];
    endsequence
    a_lamp_follow: assert property (fwd_lamp == run_fwd && rev_lamp == run_rev)
        else $error("lamp off run");
    a_fwd_cause: assert property ($rose(run_fwd) |-> $past(forward_run_key, 3))
        else $error("forward run alone");
    a_rev_cause: assert property ($rose(run_rev) |-> $past(reverse_run_key, 3))
        else $error("reverse run alone");
    a_store_pulse: assert property (nvm_write |=> !nvm_write)
        else $error("store pulse long");
    a_fault_set: assert property (fault_event |=> fault_latched)
        else $error("fault not latched");
    a_fault_clear: assert property ($fell(fault_latched) |->
        $past(reset_key, 3) || $past(fault_clear_input, 3)) else $error("fault cleared alone");
    a_din_sum: assert property (din_steady ##0 display_kind == 4'h5 |->
        display_value == {8'h00, multifunction_inputs}) else $error("input status wrong");
    a_din_stop: assert property ($fell(drive_running) |-> ##[1:3] display_kind != 4'h5)
        else $error("input status stopped");
endmodule : drkp_panel_monitor

bind drkp_panel drkp_panel_monitor mon (.*);

/* drkp_operator.sv */
// Operator model pressing panel keys, contacts chattering on press
`timescale 1ns/100ps
module drkp_operator (
    // Clock
    input wire logic hclk,
    // Keys and fault-clear terminal, high when pressed
    output logic [10:0] keys
);
    initial keys = 11'h000;
    // Released long enough for the debouncer to re-arm before the next press
    task press(input int k);
        keys[k] <= 1'b1;
        @(posedge hclk) keys[k] <= 1'b0;
        @(posedge hclk) keys[k] <= 1'b1;
        repeat (20) @(posedge hclk);
        keys[k] <= 1'b0;
        repeat (12) @(posedge hclk);
    endtask : press
endmodule : drkp_operator

/* drkp_panel_test.sv */
// Self-checking bench of the keypad panel
`timescale 1ns/100ps
module drkp_panel_test;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_ph, drive_running, fault_event;
    logic run_fwd, run_rev, fault_latched, nvm_write, fwd_lamp, rev_lamp, cursor_flash;
    logic [1:0] htrans, cursor_pos;
    logic [3:0] display_kind;
    logic [4:0] nvm_addr;
    logic [7:0] haddr, multifunction_inputs;
    logic [10:0] keys;
    logic [15:0] panel_pot_input, ext_speed_input, out_freq, out_current, out_voltage;
    logic [15:0] unitless_value, speed_cmd, display_value, nvm_data, mv[5];
    logic [31:0] hwdata, hrdata;
    logic [63:0] exp_rd[$];
    logic [20:0] exp_nvm[$];
    int error_cnt, checked;
    int ks[8] = '{6, 6, 7, 8, 6, 6, 7, 8};
    int ss[8] = '{4, 0, 8, 0, 4, 4, 4, 0};

    drkp_panel #(.DB_CYCLES(18'h4)) dut (.*, .hsize(3'h2), .hready(hreadyout),
        .param_mode_key(keys[0]), .data_key(keys[1]), .enter_key(keys[2]),
        .shift_key(keys[3]), .up_key(keys[4]), .down_key(keys[5]),
        .forward_run_key(keys[6]), .reverse_run_key(keys[7]), .stop_key(keys[8]),
        .reset_key(keys[9]), .fault_clear_input(keys[10]));
    drkp_operator op (.hclk(hclk), .keys(keys));

    task wrap_up;
        if (error_cnt == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    task cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp

    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        rd_ph <= !w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_ph <= 1'b0;
    endtask : bus

    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        exp_rd.push_back({m, e});
        bus(1'b0, a, 32'h0);
    endtask : rd

    // Read data is taken at the edge that closes the data phase
    always @(posedge hclk) begin
        if (rd_ph === 1'b1 && hreadyout === 1'b1) begin
            cmp(hrdata & exp_rd[0][63:32], exp_rd[0][31:0]);
            cmp(32'(hresp), 32'h0);
            void'(exp_rd.pop_front());
        end
        if (nvm_write === 1'b1 && exp_nvm.size() > 0)
            cmp({11'h0, nvm_addr, nvm_data}, {11'h0, exp_nvm.pop_front()});
    end

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    initial begin
        #400000;
        error_cnt++;
        wrap_up();
    end

    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, rd_ph, drive_running, fault_event} = '0;
        error_cnt = 0;
        checked = 0;
        void'($urandom(39647));
        {panel_pot_input, ext_speed_input, out_freq, out_current, out_voltage, unitless_value,
            multifunction_inputs} = 104'({$urandom, $urandom, $urandom, $urandom});
        hresetn = 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(8'h14, 32'hFFFFFFFF, 32'h0);
        cmp(32'(speed_cmd), 32'(panel_pot_input));
        bus(1'b1, 8'h04, 32'h123);
        bus(1'b1, 8'h08, 32'h8);
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, 8'h0C, 32'(2 * i));
            op.press(4);
            rd(8'h04, 32'hFFFF, 32'h124);
            cmp(32'(speed_cmd), 32'(i ? ext_speed_input : 16'h124));
        end
        op.press(5);
        rd(8'h10, 32'hFFFFF, 32'h60004);
        for (int i = 0; i < 2; i++) begin
            op.press(0);
            rd(8'h00, 32'h3, 32'(i));
        end
        bus(1'b1, 8'h08, 32'h3);
        bus(1'b1, 8'h0C, 32'h0);
        op.press(5);
        op.press(1);
        rd(8'h00, 32'h63, 32'h2);
        op.press(4);
        op.press(3);
        rd(8'h00, 32'h63, 32'h22);
        cmp(32'({cursor_flash, cursor_pos}), 32'h5);
        op.press(5);
        exp_nvm.push_back({5'h3, 16'h0F00});
        op.press(2);
        rd(8'h00, 32'h3, 32'h1);
        cmp(32'(cursor_flash), 32'h0);
        op.press(1);
        op.press(4);
        op.press(9);
        exp_nvm.push_back({5'h3, 16'h0F00});
        op.press(1);
        rd(8'h00, 32'h3, 32'h1);
        op.press(0);
        for (int i = 0; i < 8; i++) begin
            if (i == 4) begin
                bus(1'b1, 8'h08, 32'h9);
                bus(1'b1, 8'h0C, 32'h1);
            end
            op.press(ks[i]);
            rd(8'h00, 32'hC, 32'(ss[i]));
            cmp(32'({rev_lamp, fwd_lamp, 2'b00}), 32'(ss[i]));
        end
        drive_running <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            {out_freq, out_current, out_voltage, unitless_value} <= {$urandom, $urandom};
            op.press(3);
            mv = '{out_freq, out_current, out_voltage, unitless_value, 16'h0};
            rd(8'h10, (i < 4) ? 32'hFFFFF : 32'hF0000, {12'h0, 4'((i + 1) % 5), mv[i]});
        end
        bus(1'b1, 8'h08, 32'h4);
        bus(1'b1, 8'h0C, 32'hB);
        multifunction_inputs <= 8'($urandom);
        repeat (6) @(posedge hclk);
        rd(8'h10, 32'hFFFFF, {12'h0, 4'h5, 8'h0, multifunction_inputs});
        drive_running <= 1'b0;
        repeat (3) @(posedge hclk);
        rd(8'h10, 32'hF0000, 32'h0);
        for (int i = 0; i < 2; i++) begin
            fault_event <= 1'b1;
            @(posedge hclk);
            fault_event <= 1'b0;
            rd(8'h00, 32'h10, 32'h10);
            op.press(9 + i);
            rd(8'h00, 32'h10, 32'h0);
        end
        cmp(32'(exp_nvm.size()), 32'h0);
        wrap_up();
    end
endmodule : drkp_panel_test
